/* hdl/rtc_pkg.sv */
package rtc_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 16;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_TIME_CTRL    = 8'h17;
   localparam logic [7:0] IDX_SUMMARY      = 8'h18;
   localparam logic [7:0] IDX_EVENT_STATUS = 8'h19;
   localparam logic [ADDR_W-1:0] ADDR_TIME_CTRL    = 8'(IDX_TIME_CTRL * 4);
   localparam logic [ADDR_W-1:0] ADDR_SUMMARY      = 8'(IDX_SUMMARY * 4);
   localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 8'(IDX_EVENT_STATUS * 4);

   // rtc_time_control fields
   localparam int unsigned BIT_HALT_REQ = 11;
   localparam int unsigned BIT_HALTED   = 10;
   localparam int unsigned PER_LSB      = 4;
   localparam int unsigned PER_W        = 3;
   localparam int unsigned SQW_LSB      = 0;
   localparam int unsigned SQW_W        = 4;
   localparam logic [PER_W-1:0] PER_RESET = 3'h2;
   localparam logic [SQW_W-1:0] SQW_RESET = 4'h0;
   localparam logic             HALT_RESET = 1'h0;

   // interrupt_summary flag positions
   localparam int unsigned BIT_OVERCURRENT  = 13;
   localparam int unsigned BIT_UNDERVOLTAGE = 12;
   localparam int unsigned BIT_CURRENT_SINK = 9;
   localparam int unsigned BIT_EXTERNAL     = 8;
   localparam int unsigned BIT_CODEC        = 7;
   localparam int unsigned BIT_PIN          = 6;
   localparam int unsigned BIT_AUX_CONV     = 5;
   localparam int unsigned BIT_RTC          = 4;
   localparam int unsigned BIT_SYSTEM       = 3;
   localparam int unsigned BIT_CHARGER      = 2;
   localparam int unsigned BIT_USB          = 1;
   localparam int unsigned BIT_WAKEUP       = 0;
   localparam logic [REG_W-1:0] SUMMARY_MASK  = 16'h33ff;
   localparam logic [REG_W-1:0] SUMMARY_RESET = 16'h0000;

   // second-level event status
   localparam int unsigned BIT_PER_EVENT = 7;
   localparam logic        EVENT_RESET   = 1'h0;

   // timebase
   localparam int unsigned PRESC_W   = 15;
   localparam int unsigned ROLL_W    = 5;
   localparam logic [3:0]  TRIM_MAX  = 4'h8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0]
   {
      RATE_OFF   = 3'h0,
      RATE_SEC   = 3'h1,
      RATE_MIN   = 3'h2,
      RATE_HOUR  = 3'h3,
      RATE_DAY   = 3'h4,
      RATE_MONTH = 3'h5
   } per_rate_e;

   typedef enum logic [1:0]
   {
      SEL_NONE, SEL_CTRL, SEL_SUMMARY, SEL_EVENT
   } reg_sel_e;

   typedef enum logic [1:0]
   {
      PS_IDLE  = 2'b00,
      PS_ARMED = 2'b01,
      PS_PULSE = 2'b11
   } per_state_e;
endpackage

/* hdl/rtc_tb_if.sv */
interface rtc_tb_if;
   logic       tick;
   logic [3:0] sqw_rate;
   logic [3:0] trim_ticks;
   logic       square_wave;

   modport timebase (output tick, output square_wave,
                     input sqw_rate, input trim_ticks);
   modport control  (input tick, input square_wave,
                     output sqw_rate, output trim_ticks);
endinterface

/* hdl/rtc_timebase.sv */
module rtc_timebase
(
   input wire logic     aclk,        // system clock
   input wire logic     aresetn,     // sync reset, active low
   input wire logic     clk32k_pin,  // 32768 Hz timebase from pin
   rtc_tb_if.timebase   tb           // tick and square wave
);
   logic [2:0]                      sync_ff;
   logic                            level_ff;
   logic                            tick_ff;
   logic [rtc_pkg::PRESC_W-1:0]     presc_ff;
   logic [3:0]                      hold_ff;
   logic                            sqw_ff;

   wire       agree     = sync_ff[1] == sync_ff[2];
   wire       nxt_level = agree ? sync_ff[2] : level_ff;
   wire       tick_rise = nxt_level & ~level_ff;
   wire       wrap      = &presc_ff;
   wire [3:0] tap_idx   = (tb.sqw_rate == 4'h0) ? 4'h0 : 4'hf - tb.sqw_rate;
   wire       nxt_sqw   = (tb.sqw_rate != 4'h0) & presc_ff[tap_idx];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_ff  <= 3'h0;
         level_ff <= 1'b0;
         tick_ff  <= 1'b0;
         sqw_ff   <= 1'b0;
      end
      else
      begin
         sync_ff  <= {sync_ff[1:0], clk32k_pin};
         level_ff <= nxt_level;
         tick_ff  <= tick_rise;
         sqw_ff   <= nxt_sqw;
      end
   end

   // trim holds the divider at zero after the seconds wrap: low phase grows
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         presc_ff <= '0;
         hold_ff  <= 4'h0;
      end
      else if (tick_ff)
      begin
         if (hold_ff != 4'h0)
            hold_ff <= hold_ff - 4'h1;
         else if (wrap)
         begin
            presc_ff <= '0;
            hold_ff  <= tb.trim_ticks;
         end
         else
            presc_ff <= presc_ff + 15'h1;
      end
   end

   assign tb.tick        = tick_ff;
   assign tb.square_wave = sqw_ff;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_sqw_off;
      tb.sqw_rate == 4'h0 |=> !tb.square_wave;
   endproperty
   a_sqw_off: assert property (p_sqw_off)
      else $error("square wave active while switched off");

   property p_sqw_fast;
      (tb.sqw_rate == 4'hf) && $stable(tb.sqw_rate)
         |=> tb.square_wave == $past(presc_ff[0]);
   endproperty
   a_sqw_fast: assert property (p_sqw_fast)
      else $error("fastest square wave does not follow divider");

   property p_trim_bound;
      hold_ff <= rtc_pkg::TRIM_MAX;
   endproperty
   a_trim_bound: assert property (p_trim_bound)
      else $error("trim stretch exceeds eight timebase periods");
endmodule

/* hdl/rtc_tick_irq.sv */
// Our own choice: register access over AXI4-Lite.
module rtc_tick_irq
(
   input  wire logic        aclk,          // system clock, 100 MHz
   input  wire logic        aresetn,       // sync reset, active low
   input  wire logic        clk32k_pin,    // 32768 Hz timebase pin
   input  wire logic [4:0]  rollover,      // sec/min/hour/day/month wraps
   input  wire logic [3:0]  trim_ticks,    // trim stretch at seconds wrap
   input  wire logic [15:0] group_event,   // second-level source pulses
   output wire logic        periodic_pulse,// periodic event output
   output wire logic        square_wave,   // divided square wave
   output wire logic        counter_halt,  // seconds counter stopped
   input  wire logic [7:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output wire logic        s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write byte strobes
   input  wire logic        s_axi_wvalid,  // write data valid
   output wire logic        s_axi_wready,  // write data ready
   output wire logic [1:0]  s_axi_bresp,   // write response
   output wire logic        s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [7:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output wire logic        s_axi_arready, // read address ready
   output wire logic [31:0] s_axi_rdata,   // read data
   output wire logic [1:0]  s_axi_rresp,   // read response
   output wire logic        s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready   // read data ready
);
   function automatic rtc_pkg::reg_sel_e decode(input logic [7:0] addr);
      if (addr == rtc_pkg::ADDR_TIME_CTRL)
         return rtc_pkg::SEL_CTRL;
      else if (addr == rtc_pkg::ADDR_SUMMARY)
         return rtc_pkg::SEL_SUMMARY;
      else if (addr == rtc_pkg::ADDR_EVENT_STATUS)
         return rtc_pkg::SEL_EVENT;
      else
         return rtc_pkg::SEL_NONE;
   endfunction

   // codes 110 and 111 fall through as off
   function automatic logic rate_hit(input logic [2:0] rate,
                                     input logic [4:0] roll);
      logic hit;
      hit = 1'b0;
      unique case (rate)
         rtc_pkg::RATE_SEC:   hit = roll[0];
         rtc_pkg::RATE_MIN:   hit = roll[1];
         rtc_pkg::RATE_HOUR:  hit = roll[2];
         rtc_pkg::RATE_DAY:   hit = roll[3];
         rtc_pkg::RATE_MONTH: hit = roll[4];
         default:             hit = 1'b0;
      endcase
      return hit;
   endfunction

   rtc_tb_if tb ();

   rtc_timebase u_timebase
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .clk32k_pin (clk32k_pin),
      .tb         (tb)
   );

   logic [2:0]           per_rate_ff;
   logic [3:0]           sqw_rate_ff;
   logic                 halt_req_ff;
   logic                 halted_ff;
   rtc_pkg::per_state_e  state_ff;
   rtc_pkg::per_state_e  nxt_state;
   logic [15:0]          summary_ff;
   logic                 per_event_ff;
   logic                 aw_held_ff;
   logic                 w_held_ff;
   logic [7:0]           awaddr_ff;
   logic [31:0]          wdata_ff;
   logic [3:0]           wstrb_ff;
   logic                 bvalid_ff;
   logic [1:0]           bresp_ff;
   logic                 rvalid_ff;
   logic [31:0]          rdata_ff;
   logic [1:0]           rresp_ff;

   // bus decode
   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire ar_take  = s_axi_arvalid & s_axi_arready;
   wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
   rtc_pkg::reg_sel_e wr_sel;
   rtc_pkg::reg_sel_e rd_sel;
   assign wr_sel = decode(awaddr_ff);
   assign rd_sel = decode(s_axi_araddr);
   wire wr_ctrl   = do_write & (wr_sel == rtc_pkg::SEL_CTRL);
   wire rd_sum    = ar_take & (rd_sel == rtc_pkg::SEL_SUMMARY);
   wire rd_event  = ar_take & (rd_sel == rtc_pkg::SEL_EVENT);

   // periodic event generator
   wire roll_hit    = rate_hit(per_rate_ff, rollover);
   wire pulse_start = (nxt_state == rtc_pkg::PS_PULSE) &
                      (state_ff != rtc_pkg::PS_PULSE);

   always_comb
   begin
      nxt_state = state_ff;
      if (halted_ff)
         nxt_state = rtc_pkg::PS_IDLE;
      else
      begin
         unique case (state_ff)
            rtc_pkg::PS_IDLE:
               if (roll_hit)
                  nxt_state = rtc_pkg::PS_ARMED;
            rtc_pkg::PS_ARMED:
               if (tb.tick)
                  nxt_state = rtc_pkg::PS_PULSE;
            rtc_pkg::PS_PULSE:
               if (tb.tick)
                  nxt_state = rtc_pkg::PS_IDLE;
            default:
               nxt_state = rtc_pkg::PS_IDLE;
         endcase
      end
   end

   // flag set terms; set beats the read clear
   wire [15:0] set_vec = (group_event & rtc_pkg::SUMMARY_MASK)
                       | (16'(pulse_start) << rtc_pkg::BIT_RTC);
   wire [15:0] clr_vec = rd_sum ? summary_ff : 16'h0000;
   wire [15:0] nxt_summary = (summary_ff & ~clr_vec) | set_vec;
   wire nxt_per_event = (per_event_ff & ~rd_event) | pulse_start;

   // register read values; unused bits read zero
   wire [15:0] ctrl_val = {4'h0, halt_req_ff, halted_ff, 3'h0,
                           per_rate_ff, sqw_rate_ff};
   wire [15:0] event_val = 16'(per_event_ff) << rtc_pkg::BIT_PER_EVENT;
   wire [15:0] rd_val =
      (rd_sel == rtc_pkg::SEL_CTRL)    ? ctrl_val :
      (rd_sel == rtc_pkg::SEL_SUMMARY) ? summary_ff :
      (rd_sel == rtc_pkg::SEL_EVENT)   ? event_val : 16'h0000;
   wire [1:0] rd_resp = (rd_sel == rtc_pkg::SEL_NONE) ?
                        rtc_pkg::RESP_SLVERR : rtc_pkg::RESP_OKAY;
   wire [1:0] wr_resp = (wr_sel == rtc_pkg::SEL_NONE) ?
                        rtc_pkg::RESP_SLVERR : rtc_pkg::RESP_OKAY;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         per_rate_ff <= rtc_pkg::PER_RESET;
         sqw_rate_ff <= rtc_pkg::SQW_RESET;
         halt_req_ff <= rtc_pkg::HALT_RESET;
      end
      else if (wr_ctrl)
      begin
         if (wstrb_ff[1])
            halt_req_ff <= wdata_ff[rtc_pkg::BIT_HALT_REQ];
         if (wstrb_ff[0])
         begin
            per_rate_ff <= wdata_ff[rtc_pkg::PER_LSB +: rtc_pkg::PER_W];
            sqw_rate_ff <= wdata_ff[rtc_pkg::SQW_LSB +: rtc_pkg::SQW_W];
         end
      end
   end

   // counter stops on a timebase edge, as the seconds counter would
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         halted_ff <= rtc_pkg::HALT_RESET;
      else if (tb.tick)
         halted_ff <= halt_req_ff;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_ff     <= rtc_pkg::PS_IDLE;
         summary_ff   <= rtc_pkg::SUMMARY_RESET;
         per_event_ff <= rtc_pkg::EVENT_RESET;
      end
      else
      begin
         state_ff     <= nxt_state;
         summary_ff   <= nxt_summary;
         per_event_ff <= nxt_per_event;
      end
   end

   // write channel: address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= rtc_pkg::RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (w_take)
         begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_resp;
         end
         else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   // read channel: side effects happen on the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= rtc_pkg::RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= {16'h0000, rd_val};
         rresp_ff  <= rd_resp;
      end
      else if (rvalid_ff && s_axi_rready)
         rvalid_ff <= 1'b0;
   end

   assign tb.sqw_rate   = sqw_rate_ff;
   assign tb.trim_ticks = (trim_ticks > rtc_pkg::TRIM_MAX) ?
                          rtc_pkg::TRIM_MAX : trim_ticks;

   assign periodic_pulse = (state_ff == rtc_pkg::PS_PULSE);
   assign square_wave    = tb.square_wave;
   assign counter_halt   = halted_ff;
   assign s_axi_awready  = ~aw_held_ff & ~bvalid_ff;
   assign s_axi_wready   = ~w_held_ff & ~bvalid_ff;
   assign s_axi_bvalid   = bvalid_ff;
   assign s_axi_bresp    = bresp_ff;
   assign s_axi_arready  = ~rvalid_ff;
   assign s_axi_rvalid   = rvalid_ff;
   assign s_axi_rdata    = rdata_ff;
   assign s_axi_rresp    = rresp_ff;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rate_arm;
      (state_ff == rtc_pkg::PS_IDLE) && !halted_ff &&
      ((per_rate_ff == 3'h0) || (per_rate_ff > 3'h5))
         |=> state_ff == rtc_pkg::PS_IDLE;
   endproperty
   a_rate_arm: assert property (p_rate_arm)
      else $error("periodic event armed with rate off");

   property p_min_arm;
      (state_ff == rtc_pkg::PS_IDLE) && !halted_ff &&
      (per_rate_ff == 3'h2) && rollover[1]
         |=> state_ff == rtc_pkg::PS_ARMED;
   endproperty
   a_min_arm: assert property (p_min_arm)
      else $error("minute rollover did not arm periodic event");

   property p_rate_reset;
      $rose(aresetn) |-> per_rate_ff == 3'h2;
   endproperty
   a_rate_reset: assert property (p_rate_reset)
      else $error("periodic rate not at minute after reset");

   property p_pulse_rise;
      $rose(periodic_pulse) |-> $past(tb.tick);
   endproperty
   a_pulse_rise: assert property (p_pulse_rise)
      else $error("periodic pulse rose off a timebase edge");

   property p_pulse_fall;
      $fell(periodic_pulse) |-> $past(tb.tick) || $past(halted_ff);
   endproperty
   a_pulse_fall: assert property (p_pulse_fall)
      else $error("periodic pulse ended off a timebase edge");

   property p_halt_quiet;
      halted_ff |=> !periodic_pulse;
   endproperty
   a_halt_quiet: assert property (p_halt_quiet)
      else $error("periodic pulse while counter halted");

   property p_halt_follow;
      tb.tick |=> halted_ff == $past(halt_req_ff);
   endproperty
   a_halt_follow: assert property (p_halt_follow)
      else $error("halted status did not follow halt request");

   sequence s_sum_read;
      rd_sum && (set_vec == 16'h0000);
   endsequence

   property p_sum_clear;
      s_sum_read |=> (summary_ff == 16'h0000) &&
                     (s_axi_rdata[15:0] == $past(summary_ff));
   endproperty
   a_sum_clear: assert property (p_sum_clear)
      else $error("summary read did not return then clear");

   property p_sum_reset;
      $rose(aresetn) |-> summary_ff == 16'h0000;
   endproperty
   a_sum_reset: assert property (p_sum_reset)
      else $error("summary flags not clear after reset");

   property p_sum_keep;
      rd_sum |=> (summary_ff & $past(set_vec)) == $past(set_vec);
   endproperty
   a_sum_keep: assert property (p_sum_keep)
      else $error("event lost during summary read");

   property p_group_set;
      group_event[rtc_pkg::BIT_WAKEUP] |=> summary_ff[rtc_pkg::BIT_WAKEUP];
   endproperty
   a_group_set: assert property (p_group_set)
      else $error("source event did not set summary flag");

   property p_sum_reserved;
      (summary_ff & ~rtc_pkg::SUMMARY_MASK) == 16'h0000;
   endproperty
   a_sum_reserved: assert property (p_sum_reserved)
      else $error("reserved summary bit set");

   property p_per_flag;
      pulse_start |=> per_event_ff && summary_ff[rtc_pkg::BIT_RTC];
   endproperty
   a_per_flag: assert property (p_per_flag)
      else $error("periodic pulse did not set its flags");
endmodule

/* verif/rtc_pin_source.sv */
module rtc_pin_source
#(
   parameter int HALF = 10
)
(
   input  wire logic aclk,      // system clock
   output wire logic clk32k_pin // timebase pin
);
   timeunit 1ns;
   timeprecision 100ps;
   int   cnt    = 0;
   logic pin_ff = 1'b0;
   // sped-up crystal keeps the run short; the block counts edges only
   always @(posedge aclk)
   begin
      if (cnt == HALF - 1)
      begin
         cnt <= 0;
         pin_ff <= ~pin_ff;
      end
      else
         cnt <= cnt + 1;
   end
   assign clk32k_pin = pin_ff;
endmodule

/* verif/rtc_tick_irq_tb_top.sv */
module rtc_tick_irq_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK = 20;
   logic        aclk, aresetn, clk32k_pin, bready, rready;
   logic [4:0]  rollover;
   logic [3:0]  trim_ticks, wstrb;
   logic [15:0] group_event;
   logic        periodic_pulse, square_wave, counter_halt;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid;
   logic        arvalid, arready, rvalid;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] d;
   integer      seed = 9;
   int          n_fail = 0;
   int          checks_done = 0;
   logic [15:0] ev;

   rtc_pin_source #(.HALF(TICK / 2)) i_rtc_pin_source
      (.aclk(aclk), .clk32k_pin(clk32k_pin));
   rtc_tick_irq i_rtc_tick_irq
   (
      .aclk(aclk), .aresetn(aresetn), .clk32k_pin(clk32k_pin),
      .rollover(rollover), .trim_ticks(trim_ticks),
      .group_event(group_event), .periodic_pulse(periodic_pulse),
      .square_wave(square_wave), .counter_halt(counter_halt),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready)
   );

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic hang(input string nm);
      n_fail++;
      $display("FAIL %s expected answer seen none", nm);
      complete_run();
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 200; i++)
      begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (i == 200) hang("bvalid");
      r = bresp;
      bready <= 1'b0;
   endtask

   // e rides along with the read request to hit the clearing edge
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      group_event <= e;
      for (i = 0; i < 200; i++)
      begin
         @(posedge aclk);
         group_event <= 16'h0000;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (i == 200) hang("rvalid");
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   function automatic logic [31:0] hit(int c, int b, int h);
      return 32'((c >= 1) && (c <= 5) && (b == c - 1) && (h == 0));
   endfunction

   function automatic logic [31:0] sqw_high(int code);
      return code == 0 ? 32'h0 : 32'(TICK * (1 << (15 - code)));
   endfunction

   task automatic per_case(input int c, b, h);
      int w;
      w = 0;
      wr(rtc_pkg::ADDR_TIME_CTRL, 16'((h << 11) | (c << 4)));
      repeat (3 * TICK) @(posedge aclk);
      chk("halted_pin", 32'(h), 32'(counter_halt));
      rd(rtc_pkg::ADDR_TIME_CTRL, 16'h0000);
      chk("time_ctrl", 32'((h * 32'h0c00) | (c << 4)), d);
      rd(rtc_pkg::ADDR_EVENT_STATUS, 16'h0000);
      rd(rtc_pkg::ADDR_SUMMARY, 16'h0000);
      @(posedge aclk) rollover <= 5'(1 << b);
      @(posedge aclk) rollover <= 5'h00;
      repeat (4 * TICK)
      begin
         @(posedge aclk);
         if (periodic_pulse === 1'b1) w++;
      end
      chk("pulse_cycles", hit(c, b, h) * TICK, 32'(w));
      rd(rtc_pkg::ADDR_EVENT_STATUS, 16'h0000);
      chk("event_flag", hit(c, b, h) << 7, d);
      rd(rtc_pkg::ADDR_SUMMARY, 16'h0000);
      chk("rtc_summary", hit(c, b, h) << 4, d);
   endtask

   task automatic sqw_case(input int code);
      int w, i;
      w = 0;
      wr(rtc_pkg::ADDR_TIME_CTRL, 16'(code));
      // skip the phase cut short by the rate change
      for (i = 0; i < 5000 && square_wave !== 1'b0; i++) @(posedge aclk);
      if (i == 5000) hang("sqw_low");
      // with the output off the wait for a high phase must run out
      for (i = 0; i < 5000 && square_wave !== 1'b1; i++) @(posedge aclk);
      if (i == 5000 && code != 0) hang("sqw_high");
      while (square_wave === 1'b1 && w < 5000)
      begin
         w++;
         @(posedge aclk);
      end
      chk("sqw_high", sqw_high(code), 32'(w));
   endtask

   initial
   begin
      {aresetn, rollover, group_event, awaddr, araddr} <= '0;
      {awvalid, wvalid, bready, arvalid, rready, wdata} <= '0;
      wstrb <= 4'hf;
      trim_ticks <= 4'($unsigned($random(seed)) % 9);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(rtc_pkg::ADDR_TIME_CTRL, 16'h0000);
      chk("ctrl_reset", 32'h00000020, d);
      rd(rtc_pkg::ADDR_SUMMARY, 16'h0000);
      chk("summary_reset", 32'h00000000, d);
      rd(8'h00, 16'h0000);
      chk("unmapped_rresp", 32'(rtc_pkg::RESP_SLVERR), 32'(r));
      chk("unmapped_rdata", 32'h00000000, d);
      wr(8'h10, 16'hffff);
      chk("unmapped_bresp", 32'(rtc_pkg::RESP_SLVERR), 32'(r));
      per_case(2, 1, 0);
      for (int c = 0; c < 8; c++)
         per_case(c, (c >= 1 && c <= 5) ? c - 1 :
                  $unsigned($random(seed)) % 5, 0);
      per_case(3, 0, 0);
      per_case(1, 0, 1);
      per_case(1, 0, 0);
      // low byte strobe only: halt request must keep its value
      wstrb <= 4'h1;
      wr(rtc_pkg::ADDR_TIME_CTRL, 16'h0830);
      wstrb <= 4'hf;
      rd(rtc_pkg::ADDR_TIME_CTRL, 16'h0000);
      chk("strobe_low", 32'h00000030, d);
      for (int i = 0; i < 5; i++)
      begin
         ev = (i == 4) ? 16'hffff : 16'($random(seed));
         @(posedge aclk) group_event <= ev;
         @(posedge aclk) group_event <= 16'h0000;
         rd(rtc_pkg::ADDR_SUMMARY, 16'h0000);
         chk("sum", 32'(ev & rtc_pkg::SUMMARY_MASK), d);
      end
      rd(rtc_pkg::ADDR_SUMMARY, 16'h0000);
      chk("summary_cleared", 32'h00000000, d);
      ev = 16'($random(seed)) | 16'h0001;
      rd(rtc_pkg::ADDR_SUMMARY, ev);
      rd(rtc_pkg::ADDR_SUMMARY, 16'h0000);
      chk("summary_kept", 32'(ev & rtc_pkg::SUMMARY_MASK), d);
      for (int code = 12; code < 17; code++)
         sqw_case(code % 16);
      complete_run();
   end
endmodule
